// [hw/pio_decode_regs.vh]
/*
 * Address map, reset values and decode constants for the peripheral I/O
 * decoder and its timer register bank.
 * Assumes a processor that issues 24-bit addressed I/O and memory cycles.
 */
// Operation
// - Peripheral registers reachable by I/O cycles only
// - Decode uses only the 16-bit I/O address
// - Address bits 23:16 ignored in I/O decode
// - Window 0080h-00FFh routed to internal registers
// - Suppress external chip selects overlapping window
// - Unmapped window reads arbitrary, writes ignored
// - Timer control read/write, resets to zero
// - Low address: read count, write reload
// - High address: read count, write reload
`ifndef PIO_DECODE_REGS_VH
`define PIO_DECODE_REGS_VH

// ---------------------------------------------------------------
// Peripheral window
// ---------------------------------------------------------------
`define PIO_WIN_LO        16'h0080
`define PIO_WIN_HI        16'h00ff
`define PIO_WIN_PAGE      8'h00

// ---------------------------------------------------------------
// Timer register offsets
// ---------------------------------------------------------------
`define PIO_T0_CONTROL    16'h0800
`define PIO_T0_LOW        16'h0081
`define PIO_T0_HIGH       16'h0082
`define PIO_T1_CONTROL    16'h0083
`define PIO_T1_LOW        16'h0084
`define PIO_T1_HIGH       16'h0085
`define PIO_T2_CONTROL    16'h0086
`define PIO_T2_LOW        16'h0087
`define PIO_T2_HIGH       16'h0088

// ---------------------------------------------------------------
// Reset and fill values, timer and chip select counts
// ---------------------------------------------------------------
`define PIO_CTL_RST       8'h00
`define PIO_RELOAD_RST    8'h00
`define PIO_UNMAPPED_RD   8'h00
`define PIO_NUM_TIMERS    3
`define PIO_NUM_CS        4

`endif

// [hw/pio_timer_regs.v]
/*
 * One timer's software registers: control byte and 16-bit reload value.
 * Assumes single-cycle write strobes from the decoder, already qualified.
 */
`timescale 1ns/1ps
`include "pio_decode_regs.vh"

module pio_timer_regs
(
   input  wire        sys_clk,
   input  wire        reset_n,
   input  wire        wrCtl,
   input  wire        wrLow,
   input  wire        wrHigh,
   input  wire [7:0]  wrData,
   output reg  [7:0]  ctl_ff,
   output reg  [15:0] reload_ff,
   output reg         reloadWr_ff
);

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         ctl_ff      <= `PIO_CTL_RST;
         reload_ff   <= {`PIO_RELOAD_RST, `PIO_RELOAD_RST};
         reloadWr_ff <= 1'b0;
      end
      else
      begin
         if (wrCtl)
            ctl_ff <= wrData;
         if (wrLow)
            reload_ff[7:0] <= wrData;
         if (wrHigh)
            reload_ff[15:8] <= wrData;
         reloadWr_ff <= wrLow | wrHigh;
      end
   end

endmodule // pio_timer_regs

// [hw/pio_decode.v]
/*
 * Peripheral I/O decoder: routes processor I/O cycles in the on-chip
 * window to the timer register bank, blocks overlapping external I/O
 * chip selects and answers reads.
 * Assumes all inputs synchronous to sys_clk; count values come from the
 * timer counting logic outside this block.
 */
`timescale 1ns/1ps
`include "pio_decode_regs.vh"

module pio_decode
(
   input  wire        sys_clk,
   input  wire        reset_n,
   input  wire [23:0] busAddr,
   input  wire        ioReq_n,
   input  wire        memReq_n,
   input  wire        rdStrobe_n,
   input  wire        wrStrobe_n,
   input  wire [7:0]  wrData,
   input  wire [47:0] timerCount,
   input  wire [3:0]  csMatch,
   input  wire [3:0]  csIsIo,
   input  wire [31:0] csLowBound,
   input  wire [31:0] csHighBound,
   output reg  [7:0]  rdData_ff,
   output reg         rdValid_ff,
   output reg         wrDone_ff,
   output reg         intSel_ff,
   output reg         unmapped_ff,
   output reg  [3:0]  extCs_n_ff,
   output wire [23:0] timerCtl,
   output wire [47:0] timerReload,
   output wire [2:0]  reloadWr
);

   // ---------------------------------------------------------------
   // Cycle qualification
   // ---------------------------------------------------------------
   wire        ioRd;
   wire        ioWr;
   wire        memCyc;
   wire [15:0] ioAddr;
   wire        inWindow;
   reg         ioRdPrev_ff;
   reg         ioWrPrev_ff;
   wire        rdStart;
   wire        wrStart;

   assign ioRd   = ~ioReq_n & memReq_n & ~rdStrobe_n;
   assign ioWr   = ~ioReq_n & memReq_n & ~wrStrobe_n;
   assign memCyc = ~memReq_n;

   assign ioAddr = busAddr[15:0];

   assign inWindow = (ioAddr >= `PIO_WIN_LO) && (ioAddr <= `PIO_WIN_HI);

   // One access per strobe, even if the strobe spans wait states
   assign rdStart = ioRd & ~ioRdPrev_ff;
   assign wrStart = ioWr & ~ioWrPrev_ff;

   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         ioRdPrev_ff <= 1'b0;
         ioWrPrev_ff <= 1'b0;
      end
      else
      begin
         ioRdPrev_ff <= ioRd;
         ioWrPrev_ff <= ioWr;
      end
   end

   // ---------------------------------------------------------------
   // Per-timer address decode and registers
   // ---------------------------------------------------------------
   wire [2:0]  hitCtl;
   wire [2:0]  hitLow;
   wire [2:0]  hitHigh;
   wire [23:0] rdPart;
   wire [2:0]  timerHit;

   genvar t;
   generate
      for (t = 0; t < `PIO_NUM_TIMERS; t = t + 1)
      begin : gTimer
         wire [15:0] ctlAddr;
         wire [15:0] lowAddr;
         wire [15:0] highAddr;
         wire [7:0]  ctlByte;
         wire [15:0] cntWord;

         assign ctlAddr  = (t == 0) ? `PIO_T0_CONTROL :
                           (t == 1) ? `PIO_T1_CONTROL : `PIO_T2_CONTROL;
         assign lowAddr  = (t == 0) ? `PIO_T0_LOW :
                           (t == 1) ? `PIO_T1_LOW : `PIO_T2_LOW;
         assign highAddr = (t == 0) ? `PIO_T0_HIGH :
                           (t == 1) ? `PIO_T1_HIGH : `PIO_T2_HIGH;

         assign hitCtl[t]  = (ioAddr == ctlAddr);
         assign hitLow[t]  = (ioAddr == lowAddr);
         assign hitHigh[t] = (ioAddr == highAddr);
         assign timerHit[t] = hitCtl[t] | hitLow[t] | hitHigh[t];

         assign cntWord = timerCount[16*t +: 16];
         assign ctlByte = timerCtl[8*t +: 8];

         assign rdPart[8*t +: 8] =
              ({8{hitCtl[t]}}  & ctlByte)
            | ({8{hitLow[t]}}  & cntWord[7:0])
            | ({8{hitHigh[t]}} & cntWord[15:8]);

         pio_timer_regs uRegs
         (
            .sys_clk     (sys_clk),
            .reset_n     (reset_n),
            .wrCtl       (wrStart & hitCtl[t]),
            .wrLow       (wrStart & hitLow[t]),
            .wrHigh      (wrStart & hitHigh[t]),
            .wrData      (wrData),
            .ctl_ff      (timerCtl[8*t +: 8]),
            .reload_ff   (timerReload[16*t +: 16]),
            .reloadWr_ff (reloadWr[t])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Read data selection
   // ---------------------------------------------------------------
   wire       anyHit;
   wire       internal;
   reg  [7:0] rdSel;
   integer    k;

   assign anyHit   = |timerHit;
   // The relocated timer 0 control sits outside the window but is
   // still answered internally
   assign internal = inWindow | anyHit;

   always @*
   begin
      rdSel = 8'h00;
      for (k = 0; k < `PIO_NUM_TIMERS; k = k + 1)
         rdSel = rdSel | rdPart[8*k +: 8];
      if (!anyHit)
         rdSel = `PIO_UNMAPPED_RD;
   end

   // ---------------------------------------------------------------
   // Bus answer registers
   // ---------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         rdData_ff   <= 8'h00;
         rdValid_ff  <= 1'b0;
         wrDone_ff   <= 1'b0;
         intSel_ff   <= 1'b0;
         unmapped_ff <= 1'b0;
      end
      else
      begin
         rdValid_ff <= rdStart & internal;
         wrDone_ff  <= wrStart & internal;
         if (rdStart & internal)
            rdData_ff <= rdSel;
         intSel_ff  <= (ioRd | ioWr) & internal;
         unmapped_ff <= (rdStart | wrStart) & inWindow & ~anyHit;
      end
   end

   // ---------------------------------------------------------------
   // External I/O chip select gating
   // ---------------------------------------------------------------
   wire [3:0] csOverlap;
   wire [3:0] csAllow;

   genvar c;
   generate
      for (c = 0; c < `PIO_NUM_CS; c = c + 1)
      begin : gCs
         wire [7:0] lo;
         wire [7:0] hi;

         assign lo = csLowBound[8*c +: 8];
         assign hi = csHighBound[8*c +: 8];
         // Bounds compare against address bits 15:8, so the window
         // page overlaps whenever it lies inside the programmed range
         // overlap blocks the select
         assign csOverlap[c] = (lo <= `PIO_WIN_PAGE) &&
                               (hi >= `PIO_WIN_PAGE);
         assign csAllow[c] = csMatch[c] & csIsIo[c] & ~csOverlap[c]
                             & ~internal & (ioRd | ioWr) & ~memCyc;
      end
   endgenerate

   always @(posedge sys_clk)
   begin
      if (!reset_n)
         extCs_n_ff <= 4'hf;
      else
         extCs_n_ff <= ~csAllow;
   end

endmodule // pio_decode

// [testbench/pio_decode_properties.sv]
/* Port assertions for the peripheral I/O decoder.
   Assumes one clock and the bench keeping the bus idle during reset. */
`timescale 1ns/1ps
module pio_decode_properties
(
   input wire        sys_clk,
   input wire        reset_n,
   input wire [23:0] busAddr,
   input wire        ioReq_n,
   input wire        memReq_n,
   input wire        rdStrobe_n,
   input wire        wrStrobe_n,
   input wire [7:0]  wrData,
   input wire [47:0] timerCount,
   input wire [31:0] csLowBound,
   input wire [7:0]  rdData_ff,
   input wire        rdValid_ff,
   input wire        wrDone_ff,
   input wire        unmapped_ff,
   input wire [3:0]  extCs_n_ff,
   input wire [23:0] timerCtl,
   input wire [47:0] timerReload
);
   wire        ioRd = !ioReq_n && memReq_n && !rdStrobe_n;
   wire        ioWr = !ioReq_n && memReq_n && !wrStrobe_n;
   wire [15:0] a = busAddr[15:0];
   wire        inWin = (a[15:7] == 9'h001) || (a == 16'h0800);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   rd_answer_a: assert property
      ($rose(ioRd) && inWin |=> rdValid_ff)
      else $error("window read not answered");
   mem_ignore_a: assert property
      (!memReq_n |=> !rdValid_ff && !wrDone_ff)
      else $error("memory cycle answered");
   out_window_a: assert property
      (($rose(ioRd) || $rose(ioWr)) && !inWin |=> !rdValid_ff && !wrDone_ff)
      else $error("outside access answered");
   count_low_a: assert property
      (rdValid_ff && $past(a) == 16'h0084
         |-> rdData_ff == $past(timerCount[23:16]))
      else $error("bad count");
   reload_high_a: assert property
      ($rose(ioWr) && a == 16'h0085 |=> timerReload[31:24] == $past(wrData))
      else $error("bad reload");
   ctl_write_a: assert property
      ($rose(ioWr) && a == 16'h0083 |=> timerCtl[15:8] == $past(wrData))
      else $error("bad control");
   unmapped_hold_a: assert property
      (unmapped_ff |-> $stable(timerCtl) && $stable(timerReload))
      else $error("state hit");
   cs_overlap_a: assert property
      (csLowBound[7:0] == 8'h00 |=> extCs_n_ff[0])
      else $error("overlapping select driven");
   cover property ($rose(ioWr) && a == 16'h0084);
   cover property (unmapped_ff);
   cover property (!extCs_n_ff[0]);
endmodule // pio_decode_properties

bind pio_decode pio_decode_properties chk_inst (.sys_clk, .reset_n,
   .busAddr, .ioReq_n, .memReq_n, .rdStrobe_n, .wrStrobe_n, .wrData,
   .timerCount, .csLowBound, .rdData_ff, .rdValid_ff, .wrDone_ff,
   .unmapped_ff, .extCs_n_ff, .timerCtl, .timerReload);

// [testbench/pio_cpu_model.sv]
/* Processor model issuing one I/O or memory cycle per call.
   Assumes the decoder answers on the taking edge, for one cycle. */
`timescale 1ns/1ps
module pio_cpu_model
(
   input  wire        sys_clk,
   input  wire [7:0]  rdData_ff,
   input  wire        rdValid_ff,
   input  wire        wrDone_ff,
   output reg  [23:0] busAddr,
   output reg         ioReq_n,
   output reg         memReq_n,
   output reg         rdStrobe_n,
   output reg         wrStrobe_n,
   output reg  [7:0]  wrData
);
   initial
   begin
      {ioReq_n, memReq_n, rdStrobe_n, wrStrobe_n} = 4'hf;
      busAddr = 24'h000000;
      wrData = 8'h00;
   end
   task automatic cyc(input bit mem, wr, input logic [23:0] ad,
      input logic [7:0] d, output logic [7:0] q, output bit ans);
      @(negedge sys_clk);
      // sixteen-bit I/O address, top byte whatever caller gives
      busAddr = ad;
      wrData = d;
      memReq_n = !mem;
      ioReq_n = mem;
      rdStrobe_n = wr;
      wrStrobe_n = !wr;
      @(posedge sys_clk);
      // Answer pulses stand until the next edge; sample them settled
      @(negedge sys_clk);
      q = rdData_ff;
      ans = rdValid_ff | wrDone_ff;
      @(posedge sys_clk);
      @(negedge sys_clk);
      {ioReq_n, memReq_n, rdStrobe_n, wrStrobe_n} = 4'hf;
      // Released lines flip so a stale value cannot pass
      busAddr = ~busAddr;
      wrData = ~wrData;
   endtask
endmodule // pio_cpu_model

// [testbench/testbench.sv]
/* Random I/O cycles against the decoder, checked by a shadow model.
   Assumes pio_cpu_model drives the bus; counts and selects random. */
`timescale 1ns/1ps
module testbench;
   reg         sys_clk = 0, reset_n = 0;
   reg  [47:0] timerCount = 0;
   reg  [3:0]  csMatch = 0, csIsIo = 0, expCs;
   reg  [31:0] csLowBound = 0, csHighBound = 0;
   wire [23:0] busAddr, timerCtl;
   wire [47:0] timerReload;
   wire [7:0]  wrData, rdData_ff;
   wire [3:0]  extCs_n_ff;
   wire [2:0]  reloadWr;
   wire        ioReq_n, memReq_n, rdStrobe_n, wrStrobe_n, intSel_ff;
   wire        rdValid_ff, wrDone_ff, unmapped_ff;
   reg  [7:0]  shCtl [3], q, d;
   reg  [15:0] shRel [3], a;
   bit         mem, wr, ans, io;
   reg  [2:0]  expRw;
   int         num_errors, n_checks, cycles, k, r;
   always #5 sys_clk = ~sys_clk;
   pio_cpu_model pio_cpu_model_inst (.sys_clk, .rdData_ff, .rdValid_ff,
      .wrDone_ff, .busAddr, .ioReq_n, .memReq_n, .rdStrobe_n,
      .wrStrobe_n, .wrData);
   pio_decode pio_decode_inst (.sys_clk, .reset_n, .busAddr, .ioReq_n,
      .memReq_n, .rdStrobe_n, .wrStrobe_n, .wrData, .timerCount, .csMatch,
      .csIsIo, .csLowBound, .csHighBound, .rdData_ff, .rdValid_ff,
      .wrDone_ff, .intSel_ff, .unmapped_ff, .extCs_n_ff, .timerCtl,
      .timerReload, .reloadWr);
   task check(input string nm, input logic [47:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task stop_test;
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Code 0..8 is timer*3 + control/low/high, 9 unmapped, 10 outside
   function int code(input logic [15:0] ad);
      if (ad == 16'h0800) return 0;
      if (ad >= 16'h0081 && ad <= 16'h0088) return ad - 16'h0080;
      return (ad[15:7] == 9'h001) ? 9 : 10;
   endfunction
   function [7:0] expRd(input int c);
      if (c == 9) return 8'h00;
      case (c % 3)
         0: return shCtl[c / 3];
         1: return timerCount[16 * (c / 3) +: 8];
         default: return timerCount[16 * (c / 3) + 8 +: 8];
      endcase
   endfunction
   always @(posedge sys_clk)
      if (++cycles == 3000)
      begin
         num_errors++;
         stop_test;
      end
   initial
   begin
      void'($urandom(32'h0c9d));
      foreach (shCtl[i]) {shCtl[i], shRel[i]} = 24'h000000;
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk) reset_n = 1;
      check("ctl", timerCtl, 0);
      check("rld", timerReload, 0);
      for (int i = 0; i < 400; i++)
      begin
         if (i == 200)
         begin
            // Second reset in mid-run, after registers were written
            reset_n = 0;
            repeat (2) @(negedge sys_clk);
            reset_n = 1;
            foreach (shCtl[j]) {shCtl[j], shRel[j]} = 24'h000000;
            check("rctl", timerCtl, 0);
            check("rrld", timerReload, 0);
            check("rcs", extCs_n_ff, 4'hf);
            check("rrd", rdData_ff, 0);
         end
         @(negedge sys_clk);
         timerCount = {$urandom, $urandom};
         {csMatch, csIsIo, csHighBound} = {$urandom, $urandom};
         csLowBound = (i % 2) ? $urandom & 32'hffffff00 : $urandom;
         r = $urandom_range(0, 12);
         a = (r <= 8) ? (r == 0 ? 16'h0800 : 16'h0080 + r) : r == 9 ?
            16'h0080 : r == 10 ? 16'h00ff : r == 11 ? 16'h007f : $urandom;
         mem = $urandom_range(0, 7) == 0;
         wr = 1'($urandom);
         d = 8'($urandom);
         k = code(a);
         io = !mem && k < 10;
         expRw = 3'b000;
         if (io && wr && k < 9 && k % 3 != 0)
            expRw[k / 3] = 1'b1;
         for (int c = 0; c < 4; c++)
            expCs[c] = !(csMatch[c] && csIsIo[c] && !mem && k == 10 &&
               csLowBound[8 * c +: 8] != 8'h00);
         fork
            // top address byte random on every cycle
            pio_cpu_model_inst.cyc(mem, wr, {8'($urandom), a}, d, q, ans);
            begin
               @(negedge sys_clk);
               @(posedge sys_clk);
               #1;
               check("cs", extCs_n_ff, expCs);
               check("rdv", rdValid_ff, io && !wr);
               check("wrd", wrDone_ff, io && wr);
               check("sel", intSel_ff, io);
               check("unm", unmapped_ff, io && k == 9);
               check("rlw", reloadWr, expRw);
            end
         join
         check("ans", ans, io);
         if (io && !wr)
            check("rd", q, expRd(k));
         if (!mem && k < 9 && wr)
            case (k % 3)
               0: shCtl[k / 3] = d;
               1: shRel[k / 3][7:0] = d;
               default: shRel[k / 3][15:8] = d;
            endcase
         check("ctl", timerCtl, {shCtl[2], shCtl[1], shCtl[0]});
         check("rld", timerReload, {shRel[2], shRel[1], shRel[0]});
      end
      stop_test;
   end
endmodule // testbench
